// file: pdr_pkg.sv
// Shared constants for the divider, readback and write-lock register slice.
// Assumes one core clock at 100 MHz on both ends of the serial link.
`default_nettype none
package pdr_pkg;
	// Core clock rate
	localparam int PDR_CLK_MHZ = 100;
	// Frame layout: 32 bits, MSB first, address in the low five bits
	localparam int PDR_FRAME_W = 32;
	localparam int PDR_ADDR_W = 5;
	localparam int PDR_DATA_LSB = 5;
	// Register addresses
	localparam logic [4:0] PDR_REG_RB_ECHO = 5'h0C;
	localparam logic [4:0] PDR_REG_R26 = 5'h1A;
	localparam logic [4:0] PDR_REG_PLL1 = 5'h1B;
	localparam logic [4:0] PDR_REG_DIV = 5'h1C;
	localparam logic [4:0] PDR_REG_OSC = 5'h1D;
	localparam logic [4:0] PDR_REG_FB = 5'h1E;
	localparam logic [4:0] PDR_REG_LOCK = 5'h1F;
	localparam logic [4:0] PDR_REG_RSV9 = 5'h09;
	localparam logic [4:0] PDR_REG_RSV_LO = 5'h10;
	localparam logic [4:0] PDR_REG_RSV_HI = 5'h17;
	// Field positions
	localparam int PDR_L1_REF_MSB = 19;
	localparam int PDR_L1_REF_LSB = 6;
	localparam int PDR_L1_HIZ_BIT = 5;
	localparam int PDR_L2_REF_MSB = 31;
	localparam int PDR_L2_REF_LSB = 20;
	localparam int PDR_L1_FB_MSB = 19;
	localparam int PDR_L1_FB_LSB = 6;
	localparam int PDR_OSC_MSB = 26;
	localparam int PDR_OSC_LSB = 24;
	localparam int PDR_FAST_BIT = 23;
	localparam int PDR_NCAL_MSB = 22;
	localparam int PDR_NCAL_LSB = 5;
	localparam int PDR_PRE_MSB = 26;
	localparam int PDR_PRE_LSB = 24;
	localparam int PDR_L2_FB_MSB = 22;
	localparam int PDR_L2_FB_LSB = 5;
	localparam int PDR_RB_LE_BIT = 21;
	localparam int PDR_RB_ADDR_MSB = 20;
	localparam int PDR_RB_ADDR_LSB = 16;
	localparam int PDR_LOCK_BIT = 5;
	localparam int PDR_DBL_BIT = 29;
	localparam int PDR_R31_VALID_MSB = 5;
	// Oscillator range codes
	localparam logic [2:0] PDR_OSC_RSV = 3'h3;
	localparam logic [2:0] PDR_OSC_MAX = 3'h4;
	// Prescaler: code zero divides by eight, codes one and two by two
	localparam logic [3:0] PDR_PRE_ZERO_DIV = 4'h8;
	localparam logic [3:0] PDR_PRE_LOW_DIV = 4'h2;
	// Reset value of every stored register
	localparam logic [31:0] PDR_REG_RST = 32'h0000_0000;
	// Calibration run time and serial half period
	localparam int PDR_CAL_NS = 10000;
	localparam int PDR_CAL_CYC = PDR_CAL_NS * PDR_CLK_MHZ / 1000;
	localparam int PDR_HALF_NS = 80;
	localparam int PDR_HALF_CYC = PDR_HALF_NS * PDR_CLK_MHZ / 1000;
endpackage : pdr_pkg
`default_nettype wire

// file: pdr_link_if.sv
// Three-wire serial link plus readback data line between host and device.
// Assumes the host makes the serial clock; the device samples the three host-driven pins.
`default_nettype none
interface pdr_link_if;
	logic sclk; // Serial clock, made by the host
	logic sdata; // Write data, MSB first
	logic serial_latch_enable_pin; // Latch enable
	logic rb_data; // Readback data from the device
	modport dev (input sclk, input sdata, input serial_latch_enable_pin, output rb_data);
	modport host (output sclk, output sdata, output serial_latch_enable_pin, input rb_data);
endinterface : pdr_link_if
`default_nettype wire

// file: pdr_dev.sv
// Device end: stores registers 27 to 31, decodes dividers, runs calibration.
// Assumes link pins are asynchronous and the host keeps each bit for many clocks.
//
// Behaviour
// - Loop1 reference divide by its field, zero reserved
// - Loop1 pump pin released when hiz bit set
// - Loop2 reference 12-bit divide, zero invalid
// - Host uses reference divide one only with doubler
// - Loop1 feedback 14-bit divide, zero invalid
// - Oscillator range codes, three and above four reserved
// - Host sets fast detector above 100 MHz
// - Calibration divider replaces loop2 feedback during calibration
// - Register 30 write starts calibration in oscillator mode
// - Each calibration raises a synchronisation event
// - Prescaler code zero eight, one two two
// - Loop2 feedback 18-bit divide, zero invalid
// - Readback latch level set by register 31
// - Readback address selects register, some reserved
// - Register 12 readback shows readback address
// - Host ignores register 31 bits above five
// - Lock bit blocks writes to registers 0-30
// - Readback works whether locked or not
`default_nettype none
module pdr_dev #(
	parameter int CAL_CYCLES = pdr_pkg::PDR_CAL_CYC
) (
	input wire logic core_clk,
	input wire logic srst,
	pdr_link_if.dev link,
	input wire logic internal_osc_mode,
	output logic [13:0] loop1_ref_divider,
	output logic loop1_ref_valid,
	output logic loop1_pump_out_pin_oe_n,
	output logic [11:0] loop2_ref_divider,
	output logic loop2_ref_valid,
	output logic [13:0] loop1_fb_divider,
	output logic loop1_fb_valid,
	output logic [2:0] osc_input_range,
	output logic osc_range_valid,
	output logic loop2_fast_detector,
	output logic [3:0] loop2_prescaler,
	output logic [17:0] loop2_fb_divider,
	output logic loop2_fb_valid,
	output logic cal_busy,
	output logic sync_event,
	output logic write_protect_bit
);
	import pdr_pkg::*;

	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic sclk_prev_r;
	logic le_prev_r;
	logic sclk_s;
	logic sdata_s;
	logic le_s;
	logic sclk_rise;
	logic le_rise;
	logic [31:0] shift_r;
	logic [31:0] shift_nxt;
	// Only registers 27 to 31 are kept; lower addresses are not stored
	logic [31:0] regs_r [0:4];
	logic [31:0] regs_nxt [0:4];
	logic [31:0] rb_r;
	logic [31:0] rb_nxt;
	logic [31:0] rb_word;
	logic [31:0] cal_cnt_r;
	logic [31:0] cal_cnt_nxt;
	logic sync_r;
	logic sync_nxt;
	logic [4:0] wr_addr;
	logic [4:0] rb_addr;
	logic rb_level;
	logic locked;
	logic [2:0] pre_code;

	// Pins pass two flops; only the second stage feeds any logic
	always_ff @(posedge core_clk) begin
		if (srst) begin
			// Latch enable idles high out of reset; matching it here keeps a false latch edge away
			sync1_r <= 3'h4;
			sync2_r <= 3'h4;
			sclk_prev_r <= 1'b0;
			le_prev_r <= 1'b1;
		end else begin
			sync1_r <= {link.serial_latch_enable_pin, link.sdata, link.sclk};
			sync2_r <= sync1_r;
			sclk_prev_r <= sync2_r[0];
			le_prev_r <= sync2_r[2];
		end
	end

	assign sclk_s = sync2_r[0];
	assign sdata_s = sync2_r[1];
	assign le_s = sync2_r[2];
	assign sclk_rise = sclk_s & ~sclk_prev_r;
	assign le_rise = le_s & ~le_prev_r;
	// Address is the last five bits shifted in before the latch edge
	assign wr_addr = shift_r[PDR_ADDR_W-1:0];

	// Control fields held in register 31
	// Lock and readback fields take effect only once their frame is latched
	assign locked = regs_r[4][PDR_LOCK_BIT];
	assign rb_level = regs_r[4][PDR_RB_LE_BIT];
	assign rb_addr = regs_r[4][PDR_RB_ADDR_MSB:PDR_RB_ADDR_LSB];

	// Readback source; lock state plays no part here
	always_comb begin
		rb_word = 32'h0000_0000;
		// Reserved and unstored addresses read back as zero
		if (rb_addr == PDR_REG_RB_ECHO) begin
			rb_word[PDR_RB_ADDR_MSB:PDR_RB_ADDR_LSB] = rb_addr;
		end else if (rb_addr >= PDR_REG_PLL1) begin
			rb_word = regs_r[3'(rb_addr - PDR_REG_PLL1)];
		end
	end

	// Serial capture, register writes, readback shifter and calibration
	always_comb begin
		shift_nxt = shift_r;
		regs_nxt = regs_r;
		rb_nxt = rb_r;
		cal_cnt_nxt = cal_cnt_r;
		sync_nxt = 1'b0;
		// Calibration timer counts down; a new trigger below reloads it
		if (cal_cnt_r != 32'h0000_0000) begin
			cal_cnt_nxt = cal_cnt_r - 32'h0000_0001;
		end
		// Bits shift in only while latch enable is low
		if (sclk_rise && !le_s) begin
			shift_nxt = {shift_r[30:0], sdata_s};
		end
		if (le_rise) begin
			// Cleared so a later edge cannot replay the last frame
			shift_nxt = 32'h0000_0000;
			if (wr_addr >= PDR_REG_PLL1 && (!locked || wr_addr == PDR_REG_LOCK)) begin
				regs_nxt[3'(wr_addr - PDR_REG_PLL1)] = shift_r;
			end
			// A write dropped under lock starts no calibration and no sync
			if (wr_addr == PDR_REG_FB && !locked && internal_osc_mode) begin
				cal_cnt_nxt = 32'(CAL_CYCLES);
				sync_nxt = 1'b1;
			end
		end
		// Latch level picks when readback shifts; otherwise keep reloading
		if (le_s != rb_level) begin
			rb_nxt = rb_word;
		end else if (sclk_rise) begin
			rb_nxt = {rb_r[30:0], 1'b0};
		end
	end

	// State registers; every stored register resets to zero
	always_ff @(posedge core_clk) begin
		if (srst) begin
			shift_r <= 32'h0000_0000;
			for (int i = 0; i < 5; i++) begin
				regs_r[i] <= PDR_REG_RST;
			end
			rb_r <= 32'h0000_0000;
			cal_cnt_r <= 32'h0000_0000;
			sync_r <= 1'b0;
		end else begin
			shift_r <= shift_nxt;
			regs_r <= regs_nxt;
			rb_r <= rb_nxt;
			cal_cnt_r <= cal_cnt_nxt;
			sync_r <= sync_nxt;
		end
	end

	// Readback bit comes straight from the shifter flop
	assign link.rb_data = rb_r[31];
	assign cal_busy = cal_cnt_r != 32'h0000_0000;
	assign sync_event = sync_r;
	assign write_protect_bit = locked;

	// Divider fields; code zero passed on as is, with its valid flag low
	// Users must ignore a divider while its valid flag is low
	assign loop1_ref_divider = regs_r[0][PDR_L1_REF_MSB:PDR_L1_REF_LSB];
	assign loop1_ref_valid = loop1_ref_divider != 14'h0000;
	assign loop1_pump_out_pin_oe_n = regs_r[0][PDR_L1_HIZ_BIT];
	assign loop2_ref_divider = regs_r[1][PDR_L2_REF_MSB:PDR_L2_REF_LSB];
	assign loop2_ref_valid = loop2_ref_divider != 12'h000;
	assign loop1_fb_divider = regs_r[1][PDR_L1_FB_MSB:PDR_L1_FB_LSB];
	assign loop1_fb_valid = loop1_fb_divider != 14'h0000;
	assign osc_input_range = regs_r[2][PDR_OSC_MSB:PDR_OSC_LSB];
	assign osc_range_valid = osc_input_range != PDR_OSC_RSV && osc_input_range <= PDR_OSC_MAX;
	assign loop2_fast_detector = regs_r[2][PDR_FAST_BIT];

	// Prescaler decode
	assign pre_code = regs_r[3][PDR_PRE_MSB:PDR_PRE_LSB];
	always_comb begin
		if (pre_code == 3'h0) begin
			loop2_prescaler = PDR_PRE_ZERO_DIV;
		end else if (pre_code <= 3'h2) begin
			loop2_prescaler = PDR_PRE_LOW_DIV;
		end else begin
			loop2_prescaler = {1'b0, pre_code};
		end
	end

	// Calibration divider stands in for the normal one while calibrating
	assign loop2_fb_divider = cal_busy ? regs_r[2][PDR_NCAL_MSB:PDR_NCAL_LSB]
		: regs_r[3][PDR_L2_FB_MSB:PDR_L2_FB_LSB];
	assign loop2_fb_valid = loop2_fb_divider != 18'h0_0000;
endmodule : pdr_dev
`default_nettype wire

// file: pdr_host.sv
// Host end: turns user write and read commands into serial frames.
// Assumes the device end samples pins with a few cycles of latency.
`default_nettype none
module pdr_host #(
	parameter int HALF_CYCLES = pdr_pkg::PDR_HALF_CYC
) (
	input wire logic core_clk,
	input wire logic srst,
	pdr_link_if.host link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_read,
	input wire logic [4:0] cmd_addr,
	input wire logic [26:0] cmd_data,
	input wire logic pdf_above_100mhz,
	output logic cmd_err,
	output logic rsp_valid,
	output logic [31:0] rsp_data
);
	import pdr_pkg::*;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_SETUP = 5'b00010,
		ST_LOW = 5'b00100,
		ST_HIGH = 5'b01000,
		ST_TAIL = 5'b10000
	} pdr_hst_t;

	pdr_hst_t st_r, st_nxt;
	logic [15:0] tmr_r, tmr_nxt;
	logic [5:0] bit_r, bit_nxt;
	logic [31:0] sh_r, sh_nxt;
	logic rd_r, rd_nxt;
	logic sclk_r, sclk_nxt;
	logic sdata_r, sdata_nxt;
	logic le_r, le_nxt;
	logic rb_lvl_r, rb_lvl_nxt;
	logic dbl_r, dbl_nxt;
	logic lock_r, lock_nxt;
	// Readback pin passes two flops before the capture logic reads it
	logic rb_sync1_r, rb_sync2_r;
	logic [4:0] rb_addr_r, rb_addr_nxt;
	logic err_nxt, err_r;
	logic rsp_nxt, rsp_r;
	logic [31:0] rsp_data_r, rsp_data_nxt;
	logic [31:0] word;
	logic bad;
	logic half_done;

	assign half_done = tmr_r == 16'(HALF_CYCLES - 1);
	assign cmd_ready = st_r == ST_IDLE;

	// Outgoing word with host-side fixes and refusal checks
	always_comb begin
		word = {cmd_data, cmd_addr};
		if (cmd_addr == PDR_REG_OSC) begin
			word[PDR_FAST_BIT] = pdf_above_100mhz;
		end
		bad = 1'b0;
		if (cmd_addr == PDR_REG_DIV && word[PDR_L2_REF_MSB:PDR_L2_REF_LSB] == 12'h001 && !dbl_r) begin
			bad = 1'b1;
		end
		if (cmd_addr == PDR_REG_OSC && (word[PDR_OSC_MSB:PDR_OSC_LSB] == PDR_OSC_RSV
			|| word[PDR_OSC_MSB:PDR_OSC_LSB] > PDR_OSC_MAX)) begin
			bad = 1'b1;
		end
	end

	// Frame sequencer
	always_comb begin
		st_nxt = st_r;
		tmr_nxt = half_done ? 16'h0000 : tmr_r + 16'h0001;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		rd_nxt = rd_r;
		sclk_nxt = sclk_r;
		sdata_nxt = sdata_r;
		le_nxt = le_r;
		rb_lvl_nxt = rb_lvl_r;
		dbl_nxt = dbl_r;
		lock_nxt = lock_r;
		rb_addr_nxt = rb_addr_r;
		err_nxt = 1'b0;
		rsp_nxt = 1'b0;
		rsp_data_nxt = rsp_data_r;
		unique case (st_r)
			ST_IDLE: begin
				tmr_nxt = 16'h0000;
				le_nxt = ~rb_lvl_r; // Idle level never matches readback
				if (cmd_valid && !cmd_read && bad) begin
					err_nxt = 1'b1;
				end else if (cmd_valid) begin
					rd_nxt = cmd_read;
					sh_nxt = cmd_read ? 32'h0000_0000 : word;
					le_nxt = cmd_read ? rb_lvl_r : 1'b0;
					bit_nxt = 6'h00;
					st_nxt = ST_SETUP;
					if (!cmd_read && cmd_addr == PDR_REG_LOCK) begin
						rb_lvl_nxt = word[PDR_RB_LE_BIT];
						rb_addr_nxt = word[PDR_RB_ADDR_MSB:PDR_RB_ADDR_LSB];
						lock_nxt = word[PDR_LOCK_BIT];
					end
					// The device drops a locked write, so the shadow must not follow it
					if (!cmd_read && cmd_addr == PDR_REG_R26 && !lock_r) begin
						dbl_nxt = word[PDR_DBL_BIT];
					end
				end
			end
			ST_SETUP: begin
				if (half_done) begin
					sdata_nxt = sh_r[31];
					st_nxt = ST_LOW;
				end
			end
			ST_LOW: begin
				if (half_done) begin
					sclk_nxt = 1'b1;
					if (rd_r) begin
						rsp_data_nxt = {rsp_data_r[30:0], rb_sync2_r};
					end
					st_nxt = ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (half_done) begin
					sclk_nxt = 1'b0;
					sh_nxt = {sh_r[30:0], 1'b0};
					sdata_nxt = sh_r[30];
					bit_nxt = bit_r + 6'h01;
					if (bit_r == 6'(PDR_FRAME_W - 1)) begin
						le_nxt = rd_r ? ~rb_lvl_r : 1'b1;
						st_nxt = ST_TAIL;
					end else begin
						st_nxt = ST_LOW;
					end
				end
			end
			ST_TAIL: begin
				if (half_done) begin
					le_nxt = ~rb_lvl_r;
					sdata_nxt = 1'b0;
					rsp_nxt = rd_r;
					if (rd_r && rb_addr_r == PDR_REG_LOCK) begin
						rsp_data_nxt[31:PDR_R31_VALID_MSB+1] = '0;
					end
					st_nxt = ST_IDLE;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	// State registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_r <= ST_IDLE;
			tmr_r <= 16'h0000;
			bit_r <= 6'h00;
			sh_r <= 32'h0000_0000;
			rd_r <= 1'b0;
			sclk_r <= 1'b0;
			sdata_r <= 1'b0;
			le_r <= 1'b1;
			rb_lvl_r <= 1'b0;
			dbl_r <= 1'b0;
			lock_r <= 1'b0;
			rb_sync1_r <= 1'b0;
			rb_sync2_r <= 1'b0;
			rb_addr_r <= 5'h00;
			err_r <= 1'b0;
			rsp_r <= 1'b0;
			rsp_data_r <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			rd_r <= rd_nxt;
			sclk_r <= sclk_nxt;
			sdata_r <= sdata_nxt;
			le_r <= le_nxt;
			rb_lvl_r <= rb_lvl_nxt;
			dbl_r <= dbl_nxt;
			lock_r <= lock_nxt;
			rb_sync1_r <= link.rb_data;
			rb_sync2_r <= rb_sync1_r;
			rb_addr_r <= rb_addr_nxt;
			err_r <= err_nxt;
			rsp_r <= rsp_nxt;
			rsp_data_r <= rsp_data_nxt;
		end
	end

	assign link.sclk = sclk_r;
	assign link.sdata = sdata_r;
	assign link.serial_latch_enable_pin = le_r;
	assign cmd_err = err_r;
	assign rsp_valid = rsp_r;
	assign rsp_data = rsp_data_r;
endmodule : pdr_host
`default_nettype wire

// file: pdr_link_chk.sv
// Checker: latch timing, calibration pulse and length, decodes and write lock.
// Assumes the bench wires it beside the link interface and the device end's ports.
`default_nettype none
module pdr_link_chk #(
	parameter int CAL_CYCLES = pdr_pkg::PDR_CAL_CYC
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic serial_latch_enable_pin,
	input wire logic loop1_pump_out_pin_oe_n,
	input wire logic [2:0] osc_input_range,
	input wire logic osc_range_valid,
	input wire logic [3:0] loop2_prescaler,
	input wire logic [17:0] loop2_fb_divider,
	input wire logic loop2_fb_valid,
	input wire logic cal_busy,
	input wire logic sync_event,
	input wire logic write_protect_bit
);
	logic [15:0] busy_cnt_r;
	logic [15:0] busy_cnt_nxt;
	// Counts busy cycles in 16 bits, so the run length is checked for CAL_CYCLES up to 65535
	always_comb begin
		busy_cnt_nxt = cal_busy ? busy_cnt_r + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge core_clk) begin
		busy_cnt_r <= srst ? 16'h0000 : busy_cnt_nxt;
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);
	// Pump enable moves only once a frame has been latched
	pump_after_latch_a:
		assert property (!$stable(loop1_pump_out_pin_oe_n) |-> serial_latch_enable_pin && $past(serial_latch_enable_pin, 2))
		else $error("pump enable moved without a latch");
	sync_starts_cal_a:
		assert property (sync_event |-> $rose(cal_busy)) else $error("sync without calibration start");
	sync_pulse_a:
		assert property (sync_event |=> !sync_event) else $error("sync pulse too long");
	cal_length_a:
		assert property ($fell(cal_busy) |-> busy_cnt_r == CAL_CYCLES) else $error("calibration length wrong");
	cal_fb_hold_a:
		assert property (cal_busy && $past(cal_busy) |-> $stable(loop2_fb_divider))
		else $error("calibration divider moved");
	fb_valid_a:
		assert property (loop2_fb_valid == (loop2_fb_divider != 18'h00000)) else $error("feedback valid wrong");
	prescale_code_a:
		assert property (loop2_prescaler >= 4'h2 && loop2_prescaler <= 4'h8) else $error("prescaler out of range");
	osc_valid_a:
		assert property (osc_range_valid == (osc_input_range != 3'h3 && osc_input_range <= 3'h4))
		else $error("range valid wrong");
	// A held lock freezes the pump, prescaler and range fields and suppresses calibration
	lock_hold_a:
		assert property (write_protect_bit && $past(write_protect_bit) |->
			$stable({loop1_pump_out_pin_oe_n, loop2_prescaler, osc_input_range}) && !sync_event)
		else $error("locked register changed");
endmodule : pdr_link_chk
`default_nettype wire

// file: pll_divider_readback_lock_regs_bench.sv
// Bench for the register slice: host end drives the device end over the link.
// Assumes the package, interface, both ends and the checker compile first.
`default_nettype none
module pll_divider_readback_lock_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic internal_osc_mode = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_read = 1'b0;
	logic [4:0] cmd_addr = 5'h00;
	logic [26:0] cmd_data = 27'h0000000;
	logic pdf_above_100mhz = 1'b0;
	logic cmd_ready, cmd_err, rsp_valid, loop1_ref_valid, loop1_pump_out_pin_oe_n, loop2_ref_valid;
	logic loop1_fb_valid, osc_range_valid, loop2_fast_detector, loop2_fb_valid, cal_busy, sync_event;
	logic write_protect_bit, dbl;
	logic [31:0] rsp_data, n;
	logic [13:0] loop1_ref_divider, loop1_fb_divider;
	logic [11:0] loop2_ref_divider;
	logic [2:0] osc_input_range;
	logic [3:0] loop2_prescaler;
	logic [17:0] loop2_fb_divider, cal_fb;
	logic [7:0] syncs = 8'h00;
	logic [7:0] errs = 8'h00;
	logic [7:0] err0, sync0;
	logic [26:0] d;
	logic [31:0] mem [27:31];
	int seed = 32'h75A9CD91;
	int compares = 0;
	int miscompares = 0;
	pdr_link_if link_i ();
	pdr_dev #(.CAL_CYCLES(4)) pdr_dev_i (.link(link_i.dev), .*);
	pdr_host #(.HALF_CYCLES(5)) pdr_host_i (.link(link_i.host), .*);
	pdr_link_chk #(.CAL_CYCLES(4)) pdr_link_chk_i (.serial_latch_enable_pin(link_i.serial_latch_enable_pin), .*);
	// Free-running core clock, 10 ns period
	always #5 core_clk = ~core_clk;
	// Counts pulses; send notes both counts before each request
	always @(posedge core_clk) begin
		errs <= errs + 8'(cmd_err);
		syncs <= syncs + 8'(sync_event);
		if (cal_busy) begin
			cal_fb <= loop2_fb_divider;
		end
	end
	task automatic check(input logic [71:0] seen, input logic [71:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	// One command, held until taken, then followed until the host is idle again
	task automatic send(input logic is_rd, input logic [4:0] a, input logic [26:0] dv);
		logic busy;
		int k;
		busy = 1'b0;
		@(posedge core_clk);
		#1;
		n = $random(seed);
		err0 = errs;
		sync0 = syncs;
		cmd_valid = 1'b1;
		cmd_read = is_rd;
		cmd_addr = a;
		cmd_data = dv;
		pdf_above_100mhz = n[0];
		internal_osc_mode = n[1];
		for (k = 0; k < 3000; k++) begin
			@(posedge core_clk);
			if (cmd_valid && cmd_ready) begin
				#1;
				cmd_valid = 1'b0;
			end else if (!cmd_valid && cmd_ready && (busy || errs != err0)) begin
				break;
			end
			busy = busy | !cmd_ready;
		end
		if (k == 3000) begin
			miscompares++;
			test_done();
		end
		repeat (8) @(posedge core_clk);
	endtask : send
	// Every register-decoded device output against the stored-register model
	task automatic outs();
		logic [3:0] p;
		p = mem[30][26:24] == 3'h0 ? 4'h8 : mem[30][26:24] < 3'h3 ? 4'h2 : {1'b0, mem[30][26:24]};
		check({loop1_ref_divider, loop1_ref_valid, loop1_pump_out_pin_oe_n, loop2_ref_divider, loop2_ref_valid,
			loop1_fb_divider, loop1_fb_valid}, {mem[27][19:6], |mem[27][19:6], mem[27][5], mem[28][31:20],
			|mem[28][31:20], mem[28][19:6], |mem[28][19:6]});
		check({osc_input_range, osc_range_valid, loop2_fast_detector, loop2_prescaler, loop2_fb_divider, loop2_fb_valid,
			write_protect_bit}, {mem[29][26:24], 1'b1, mem[29][23], p, mem[30][22:5],
			|mem[30][22:5], mem[31][5]});
	endtask : outs
	task automatic wr(input logic [4:0] a, input logic [26:0] dv);
		logic [31:0] w;
		logic refuse;
		logic cal;
		w = {dv, a};
		refuse = (a == 5'h1C && w[31:20] == 12'h001 && !dbl) || (a == 5'h1D && (w[26:24] == 3'h3 || w[26:24] > 3'h4));
		send(1'b0, a, dv);
		check(8'(errs - err0), refuse);
		if (a == 5'h1D) begin
			w[23] = pdf_above_100mhz;
		end
		if (a == 5'h1A && !mem[31][5]) begin
			dbl = w[29];
		end
		cal = a == 5'h1E && internal_osc_mode && !mem[31][5];
		check(8'(syncs - sync0), cal);
		if (cal) begin
			check(cal_fb, mem[29][22:5]);
		end
		if (!refuse && a > 5'h1A && (a == 5'h1F || !mem[31][5])) begin
			mem[a] = w;
		end
		outs();
	endtask : wr
	// Selects a register at a random latch level, keeps the lock, reads it back
	task automatic rb(input logic [4:0] a);
		logic [31:0] e;
		n = $random(seed);
		d = n[26:0];
		d[15:11] = a;
		d[0] = mem[31][5];
		wr(5'h1F, d);
		e = a == 5'h0C ? {11'h000, a, 16'h0000} : a == 5'h1F ? {26'h0, mem[31][5:0]} : a > 5'h1A ? mem[a] : 32'h0;
		send(1'b1, 5'h00, 27'h0000000);
		check(rsp_data, e);
	endtask : rb
	initial begin
		for (int i = 27; i < 32; i++) begin
			mem[i] = 32'h00000000;
		end
		dbl = 1'b0;
		repeat (5) @(posedge core_clk);
		#1;
		srst = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		check({link_i.sclk, link_i.serial_latch_enable_pin}, 2'h1);
		outs();
		// Every range and prescaler code; reserved ranges are refused
		for (int c = 0; c < 8; c++) begin
			n = $random(seed);
			d = n[26:0];
			d[21:19] = c[2:0];
			wr(5'h1D, d);
			wr(5'h1E, d);
		end
		// Divide by one needs the doubler; zero dividers read as invalid
		wr(5'h1C, 27'h0008000);
		wr(5'h1A, 27'h1000000);
		wr(5'h1C, 27'h0008000);
		wr(5'h1E, 27'h0000000);
		wr(5'h1B, 27'h0000001);
		// Locked: writes dropped, readback still served
		wr(5'h1F, 27'h0000001);
		wr(5'h1B, 27'h7FFFFFE);
		wr(5'h1E, 27'h7FFFFFF);
		rb(5'h1B);
		rb(5'h0C);
		rb(5'h09);
		rb(5'h10);
		rb(5'h1F);
		wr(5'h1F, 27'h0000000);
		wr(5'h1B, 27'h7FFFFFE);
		// Random traffic to registers 26 to 31 with random readbacks
		for (int i = 0; i < 40; i++) begin
			n = $random(seed);
			d = 27'($random(seed));
			wr(5'h1A + 5'(n[2:0] % 3'h6), d);
			if (n[3]) begin
				rb(n[8:4]);
			end
		end
		test_done();
	end
endmodule : pll_divider_readback_lock_regs_bench
`default_nettype wire
